// ==== iat_regs.sv ====
// APB register bank holding the input alarm limits, hysteresis and alarm flags
//
// What this block does
// - top two hysteresis bits set alarm hysteresis
// - upper limit compares bits 15:4, resets ffff
// - lower limit compares bits 15:4, resets 0000
// - upper register bits 23:16 read zero
// - lower register upper half reads zero
// - upper register bytes at 24h to 27h
// - lower register bytes at 28h to 2bh
// - separate active and tripped upper/lower flags
// - summary bit is OR of tripped flags
`timescale 1ns/100ps
module iat_regs
    import iat_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // conversion results
    input  wire logic [11:0] SAMPLE,
    input  wire logic        SAMPLE_VALID,
    // alarm outputs
    output logic             ALARM,
    output logic             IRQ
);

    typedef struct packed {
        logic [7:0]  hyst;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [11:0] last_sample;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        alarm;
        logic        irq;
    } iat_state_s;

    iat_state_s   s_q;
    iat_state_s   s_d;
    iat_cmp_in_s  cmp_in;
    iat_cmp_out_s cmp_out;
    iat_cmp_out_s cmp_prev_q;
    logic         clr_trip;

    ////////////////////////////////////////////////////////////////////////////////
    // byte-lane merge, reused for both limit registers

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] upper_word(input iat_state_s s);
        // reserved 23:16 kept as constant zero
        return {s.hyst, 8'h00, s.upper};
    endfunction

    function automatic logic [31:0] flag_word(input iat_cmp_out_s f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[IAT_FLAG_ACT_UPPER] = f.active_upper;
        w[IAT_FLAG_ACT_LOWER] = f.active_lower;
        w[IAT_FLAG_TRP_UPPER] = f.trip_upper;
        w[IAT_FLAG_TRP_LOWER] = f.trip_lower;
        w[IAT_FLAG_SUMMARY]   = f.trip_upper | f.trip_lower;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // comparator

    always_comb begin
        cmp_in.upper        = s_q.upper[15:IAT_LIMIT_CMP_LSB];
        cmp_in.lower        = s_q.lower[15:IAT_LIMIT_CMP_LSB];
        cmp_in.hyst         = s_q.hyst[7:6];
        cmp_in.sample       = SAMPLE;
        cmp_in.sample_valid = SAMPLE_VALID;
    end

    // reading the flag word clears the tripped latches; active flags follow input
    assign clr_trip = PSEL && PENABLE && !PWRITE && s_q.ready == 1'b0
                      && PADDR == IAT_OFF_ALARM_FLAGS;

    iat_compare u_compare (
        .clk     (CLK),
        .nrst    (NRST),
        .cmp_in  (cmp_in),
        .clr_trip(clr_trip),
        .cmp_out (cmp_out)
    );

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cmp_prev_q <= '0;
        end else begin
            cmp_prev_q <= cmp_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    always_comb begin
        logic        acc;
        logic [31:0] m;
        logic [1:0]  ev;
        acc = PSEL && PENABLE && !s_q.ready;
        m   = 32'h0000_0000;
        ev  = {cmp_out.trip_lower & ~cmp_prev_q.trip_lower,
               cmp_out.trip_upper & ~cmp_prev_q.trip_upper};
        s_d = s_q;
        s_d.ready  = acc;
        s_d.slverr = 1'b0;
        s_d.rdata  = 32'h0000_0000;
        if (SAMPLE_VALID) begin
            s_d.last_sample = SAMPLE;
        end
        if (acc && PWRITE) begin
            unique case (PADDR)
                IAT_OFF_UPPER_LIMIT: begin
                    m = lane_merge(upper_word(s_q), PWDATA, PSTRB);
                    s_d.hyst  = m[31:IAT_HYST_LSB];
                    // low nibble stored as written; software keeps it zero
                    s_d.upper = m[15:0];
                end
                IAT_OFF_LOWER_LIMIT: begin
                    m = lane_merge({16'h0000, s_q.lower}, PWDATA, PSTRB);
                    s_d.lower = m[15:0];
                    // upper half dropped, never stored
                end
                IAT_OFF_IRQ_STATUS: begin
                    if (PSTRB[0]) begin
                        s_d.irq_status = s_q.irq_status & ~PWDATA[1:0];
                    end
                end
                IAT_OFF_IRQ_MASK: begin
                    if (PSTRB[0]) begin
                        s_d.irq_mask = PWDATA[1:0];
                    end
                end
                IAT_OFF_ALARM_FLAGS,
                IAT_OFF_SAMPLE: begin
                    // read-only, write ignored
                end
                default: begin
                    s_d.slverr = 1'b1;
                end
            endcase
        end else if (acc) begin
            unique case (PADDR)
                IAT_OFF_UPPER_LIMIT: s_d.rdata = upper_word(s_q);
                IAT_OFF_LOWER_LIMIT: s_d.rdata = {16'h0000, s_q.lower};
                IAT_OFF_ALARM_FLAGS: s_d.rdata = flag_word(cmp_out);
                IAT_OFF_IRQ_STATUS:  s_d.rdata = {30'h0000_0000, s_q.irq_status};
                IAT_OFF_IRQ_MASK:    s_d.rdata = {30'h0000_0000, s_q.irq_mask};
                IAT_OFF_SAMPLE:      s_d.rdata = {20'h0_0000, s_q.last_sample};
                default:             s_d.slverr = 1'b1;
            endcase
        end
        // set wins over a same-cycle clear
        s_d.irq_status = s_d.irq_status | ev;
        s_d.alarm = cmp_out.trip_upper | cmp_out.trip_lower;
        s_d.irq   = |(s_d.irq_status & s_d.irq_mask);
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            s_q             <= '0;
            s_q.hyst        <= IAT_HYST_RESET;
            s_q.upper       <= IAT_UPPER_RESET;
            s_q.lower       <= IAT_LOWER_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA  = s_q.rdata;
    assign PREADY  = s_q.ready;
    assign PSLVERR = s_q.slverr;
    assign ALARM   = s_q.alarm;
    assign IRQ     = s_q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_upper_reserved: assert property (@(posedge CLK) disable iff (!NRST)
        PREADY && $past(PADDR) == IAT_OFF_UPPER_LIMIT && !$past(PWRITE) |-> PRDATA[23:16] == 8'h00)
        else $error("upper reserved bits not zero");
    a_lower_reserved: assert property (@(posedge CLK) disable iff (!NRST)
        PREADY && $past(PADDR) == IAT_OFF_LOWER_LIMIT && !$past(PWRITE)
        |-> PRDATA[31:16] == 16'h0000)
        else $error("lower reserved bits not zero");
    a_reserved_ignored: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_LOWER_LIMIT
        && PSTRB[1:0] == 2'b00 |=> $stable(s_q.lower))
        else $error("reserved bits stored");
    a_upper_write: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_UPPER_LIMIT && PSTRB[0]
        |=> s_q.upper[7:0] == $past(PWDATA[7:0]))
        else $error("upper low byte not written");
    a_lower_write: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_LOWER_LIMIT && PSTRB[1]
        |=> s_q.lower[15:8] == $past(PWDATA[15:8]))
        else $error("lower high byte not written");
    a_summary_or: assert property (@(posedge CLK) disable iff (!NRST)
        ALARM == $past(cmp_out.trip_upper | cmp_out.trip_lower))
        else $error("summary not OR of trips");
    a_hyst_feed: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_UPPER_LIMIT && PSTRB[3]
        |=> cmp_in.hyst == $past(PWDATA[31:IAT_HYST_AMT_LSB]))
        else $error("hysteresis not from top bits");
    a_ready_one: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("apb answer not one cycle");

    a_ready_idle: assert property (@(posedge CLK) disable iff (!NRST)
        !(PSEL && PENABLE) |=> !PREADY)
        else $error("pready without access");
    a_rdata_idle: assert property (@(posedge CLK) disable iff (!NRST)
        !PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside answer");

    a_err_ready: assert property (@(posedge CLK) disable iff (!NRST)
        PSLVERR |-> PREADY)
        else $error("error without pready");
    a_write_no_data: assert property (@(posedge CLK) disable iff (!NRST)
        PREADY && $past(PWRITE) |-> PRDATA == 32'h0000_0000)
        else $error("read data on write answer");

    a_misaligned_err: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PADDR[1:0] != 2'b00 |=> PSLVERR)
        else $error("byte address not refused");
    a_mapped_no_err: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY
        && (PADDR == IAT_OFF_UPPER_LIMIT || PADDR == IAT_OFF_LOWER_LIMIT) |=> !PSLVERR)
        else $error("limit register refused");

    a_upper_readback: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == IAT_OFF_UPPER_LIMIT
        |=> PRDATA == {s_q.hyst, 8'h00, s_q.upper})
        else $error("upper read back wrong");
    a_lower_readback: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == IAT_OFF_LOWER_LIMIT
        |=> PRDATA == {16'h0000, s_q.lower})
        else $error("lower read back wrong");

    a_upper_mid_write: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_UPPER_LIMIT && PSTRB[1]
        |=> s_q.upper[15:8] == $past(PWDATA[15:8]))
        else $error("upper high byte not written");
    a_upper_lane_keep: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_UPPER_LIMIT && !PSTRB[0]
        |=> $stable(s_q.upper[7:0]))
        else $error("upper low byte changed");
    a_lower_lane_keep: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_LOWER_LIMIT && !PSTRB[0]
        |=> $stable(s_q.lower[7:0]))
        else $error("lower low byte changed");

    a_upper_res_ignored: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PWRITE && PADDR == IAT_OFF_UPPER_LIMIT
        && PSTRB == 4'b0100 |=> $stable(s_q.upper) && $stable(s_q.hyst))
        else $error("upper reserved lane stored");
    a_idle_keep: assert property (@(posedge CLK) disable iff (!NRST)
        !(PSEL && PENABLE && !PREADY && PWRITE)
        |=> $stable(s_q.upper) && $stable(s_q.lower) && $stable(s_q.hyst))
        else $error("limits changed without write");

    a_flags_summary: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == IAT_OFF_ALARM_FLAGS
        |=> PRDATA[IAT_FLAG_SUMMARY]
            == (PRDATA[IAT_FLAG_TRP_UPPER] | PRDATA[IAT_FLAG_TRP_LOWER]))
        else $error("summary bit not OR of trips");
    a_flags_reserved: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == IAT_OFF_ALARM_FLAGS
        |=> PRDATA[31:12] == 20'h0_0000 && PRDATA[9:6] == 4'h0 && PRDATA[3:1] == 3'h0)
        else $error("flag word reserved bits set");
    a_flag_active: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == IAT_OFF_ALARM_FLAGS
        |=> PRDATA[IAT_FLAG_ACT_UPPER] == $past(cmp_out.active_upper)
            && PRDATA[IAT_FLAG_ACT_LOWER] == $past(cmp_out.active_lower))
        else $error("active flags misreported");
    a_trip_clear: assert property (@(posedge CLK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == IAT_OFF_ALARM_FLAGS && !SAMPLE_VALID
        |=> !cmp_out.trip_upper && !cmp_out.trip_lower)
        else $error("tripped flags not cleared by read");

    a_irq_level: assert property (@(posedge CLK) disable iff (!NRST)
        IRQ == |(s_q.irq_status & s_q.irq_mask))
        else $error("irq not unmasked status");
    a_irq_set_upper: assert property (@(posedge CLK) disable iff (!NRST)
        cmp_out.trip_upper && !cmp_prev_q.trip_upper |=> s_q.irq_status[IAT_IRQ_UPPER])
        else $error("upper trip event lost");
    a_irq_set_lower: assert property (@(posedge CLK) disable iff (!NRST)
        cmp_out.trip_lower && !cmp_prev_q.trip_lower |=> s_q.irq_status[IAT_IRQ_LOWER])
        else $error("lower trip event lost");
    a_sample_store: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID |=> s_q.last_sample == $past(SAMPLE))
        else $error("last sample not stored");

    a_upper_no_trip: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID && SAMPLE <= s_q.upper[15:IAT_LIMIT_CMP_LSB] && !cmp_out.trip_upper
        |=> !cmp_out.trip_upper)
        else $error("upper tripped at or below limit");
    a_lower_no_trip: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID && SAMPLE >= s_q.lower[15:IAT_LIMIT_CMP_LSB] && !cmp_out.trip_lower
        |=> !cmp_out.trip_lower)
        else $error("lower tripped at or above limit");

    a_upper_hold: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID && cmp_out.active_upper
        && {1'b0, SAMPLE} + {11'h000, s_q.hyst[7:6]} >= {1'b0, s_q.upper[15:IAT_LIMIT_CMP_LSB]}
        |=> cmp_out.active_upper)
        else $error("upper released inside hysteresis");
    a_upper_release: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID
        && {1'b0, SAMPLE} + {11'h000, s_q.hyst[7:6]} < {1'b0, s_q.upper[15:IAT_LIMIT_CMP_LSB]}
        |=> !cmp_out.active_upper)
        else $error("upper not released");

    a_lower_hold: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID && cmp_out.active_lower
        && {1'b0, SAMPLE} <= {1'b0, s_q.lower[15:IAT_LIMIT_CMP_LSB]} + {11'h000, s_q.hyst[7:6]}
        |=> cmp_out.active_lower)
        else $error("lower released inside hysteresis");
    a_lower_release: assert property (@(posedge CLK) disable iff (!NRST)
        SAMPLE_VALID
        && {1'b0, SAMPLE} > {1'b0, s_q.lower[15:IAT_LIMIT_CMP_LSB]} + {11'h000, s_q.hyst[7:6]}
        |=> !cmp_out.active_lower)
        else $error("lower not released");

endmodule

// ==== iat_pkg.sv ====
// package: register map, field layout and types of the input alarm limit bank
package iat_pkg;

    localparam logic [7:0]  IAT_OFF_ALARM_FLAGS  = 8'h20;
    localparam logic [7:0]  IAT_OFF_UPPER_LIMIT  = 8'h24;
    localparam logic [7:0]  IAT_OFF_LOWER_LIMIT  = 8'h28;
    localparam logic [7:0]  IAT_OFF_IRQ_STATUS   = 8'h30;
    localparam logic [7:0]  IAT_OFF_IRQ_MASK     = 8'h34;
    localparam logic [7:0]  IAT_OFF_SAMPLE       = 8'h38;

    localparam logic [15:0] IAT_UPPER_RESET      = 16'hffff;
    localparam logic [15:0] IAT_LOWER_RESET      = 16'h0000;
    localparam logic [7:0]  IAT_HYST_RESET       = 8'h00;

    localparam int          IAT_HYST_LSB         = 24;
    localparam int          IAT_HYST_AMT_LSB     = 30;
    localparam int          IAT_LIMIT_CMP_LSB    = 4;

    localparam int          IAT_FLAG_SUMMARY     = 0;
    localparam int          IAT_FLAG_TRP_UPPER   = 4;
    localparam int          IAT_FLAG_TRP_LOWER   = 5;
    localparam int          IAT_FLAG_ACT_UPPER   = 10;
    localparam int          IAT_FLAG_ACT_LOWER   = 11;

    // irq status/mask bit positions
    localparam int          IAT_IRQ_UPPER        = 0;
    localparam int          IAT_IRQ_LOWER        = 1;

    typedef struct packed {
        logic [11:0] upper;
        logic [11:0] lower;
        logic [1:0]  hyst;
        logic [11:0] sample;
        logic        sample_valid;
    } iat_cmp_in_s;

    typedef struct packed {
        logic active_upper;
        logic active_lower;
        logic trip_upper;
        logic trip_lower;
    } iat_cmp_out_s;

endpackage

// ==== iat_compare.sv ====
// alarm comparator with hysteresis on the 12-bit conversion result
`timescale 1ns/100ps
module iat_compare
    import iat_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // compare inputs and clear request
    input  wire iat_cmp_in_s   cmp_in,
    input  wire logic          clr_trip,
    // alarm flags
    output iat_cmp_out_s       cmp_out
);

    typedef struct packed {
        iat_cmp_out_s f;
    } iat_cmp_state_s;

    iat_cmp_state_s s_q;
    iat_cmp_state_s s_d;

    always_comb begin
        logic [12:0] up_rel;
        logic [12:0] lo_rel;
        up_rel = 13'h0000;
        lo_rel = 13'h0000;
        s_d = s_q;
        if (clr_trip) begin
            s_d.f.trip_upper = 1'b0;
            s_d.f.trip_lower = 1'b0;
        end
        if (cmp_in.sample_valid) begin
            // release points shifted by the hysteresis amount
            up_rel = {1'b0, cmp_in.upper} - {11'h000, cmp_in.hyst};
            lo_rel = {1'b0, cmp_in.lower} + {11'h000, cmp_in.hyst};
            if (cmp_in.sample > cmp_in.upper) begin
                s_d.f.active_upper = 1'b1;
                s_d.f.trip_upper   = 1'b1;
            // a limit under the hysteresis has no release point, so it never clears
            end else if (cmp_in.upper >= {10'h000, cmp_in.hyst}
                         && {1'b0, cmp_in.sample} < up_rel) begin
                s_d.f.active_upper = 1'b0;
            end
            if (cmp_in.sample < cmp_in.lower) begin
                s_d.f.active_lower = 1'b1;
                s_d.f.trip_lower   = 1'b1;
            end else if ({1'b0, cmp_in.sample} > lo_rel) begin
                s_d.f.active_lower = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmp_out = s_q.f;

    a_upper_trip: assert property (@(posedge clk) disable iff (!nrst)
        cmp_in.sample_valid && cmp_in.sample > cmp_in.upper |=> cmp_out.trip_upper)
        else $error("upper trip not raised");
    a_lower_trip: assert property (@(posedge clk) disable iff (!nrst)
        cmp_in.sample_valid && cmp_in.sample < cmp_in.lower |=> cmp_out.trip_lower)
        else $error("lower trip not raised");

endmodule

// ==== test_input_alarm_threshold_regs.sv ====
// self-checking testbench for the input alarm limit register bank
`timescale 1ns/100ps
module test_input_alarm_threshold_regs
    import iat_pkg::*;
;

////////////////////////////////////////////////////////////////////////////////
typedef struct packed {
    logic [31:0] data;
    logic        is_rd;
    logic        err;
} iat_exp_s;

logic        CLK          = 1'b0;
logic        NRST         = 1'b0;
logic        PSEL         = 1'b0;
logic        PENABLE      = 1'b0;
logic        PWRITE       = 1'b0;
logic [7:0]  PADDR        = 8'h00;
logic [31:0] PWDATA       = 32'h0000_0000;
logic [3:0]  PSTRB        = 4'h0;
logic [31:0] PRDATA;
logic        PREADY;
logic        PSLVERR;
logic [11:0] SAMPLE       = 12'h000;
logic        SAMPLE_VALID = 1'b0;
logic        ALARM;
logic        IRQ;
iat_exp_s    exp_q[$];
int          fails        = 0;
int          n_tests      = 0;
int          cycles       = 0;
int          seed         = 32'h40f9;
logic [31:0] r;

iat_regs u_iat_regs (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE(SAMPLE), .SAMPLE_VALID(SAMPLE_VALID),
    .ALARM(ALARM), .IRQ(IRQ));

always #12.5 CLK = ~CLK;

////////////////////////////////////////////////////////////////////////////////
task automatic give_verdict();
    if (fails == 0 && n_tests > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask

task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
endtask

task automatic lvl(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
        fails++;
        $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
endtask

// request held until the edge that samples pready high
task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                   input logic [3:0] s, input logic [31:0] e, input logic er);
    exp_q.push_back('{e, ~wr, er});
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    PSTRB   <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(a, 1'b1, d, s, 32'h0000_0000, 1'b0);
endtask

task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000, 4'hf, e, 1'b0);
endtask

// flags land one edge after the pulse, alarm and irq a little later
task automatic samp(input logic [11:0] v);
    @(posedge CLK);
    SAMPLE       <= v;
    SAMPLE_VALID <= 1'b1;
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
endtask

////////////////////////////////////////////////////////////////////////////////
always @(posedge CLK) begin
    iat_exp_s x;
    if (PREADY === 1'b1) begin
        if (exp_q.size() == 0) begin
            fails++;
            $display("MISMATCH pready expected 0 seen 1");
        end else begin
            x = exp_q.pop_front();
            cmp("pslverr", {31'h0, x.err}, {31'h0, PSLVERR});
            if (x.is_rd && !x.err) cmp("prdata", x.data, PRDATA);
        end
    end
end

// hang guard, well above the length of the sequence
always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
        fails++;
        $display("MISMATCH cycles expected below 5000 seen 5000");
        give_verdict();
    end
end

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    rd(IAT_OFF_UPPER_LIMIT, 32'h0000_ffff);
    rd(IAT_OFF_LOWER_LIMIT, 32'h0000_0000);
    wr(IAT_OFF_UPPER_LIMIT, 32'hffff_fff0, 4'hf);
    rd(IAT_OFF_UPPER_LIMIT, 32'hff00_fff0);
    wr(IAT_OFF_LOWER_LIMIT, 32'hffff_fff0, 4'hf);
    rd(IAT_OFF_LOWER_LIMIT, 32'h0000_fff0);
    // single byte lanes: top byte of upper, second byte of lower
    wr(IAT_OFF_UPPER_LIMIT, 32'h1234_5670, 4'b1000);
    rd(IAT_OFF_UPPER_LIMIT, 32'h1200_fff0);
    wr(IAT_OFF_LOWER_LIMIT, 32'ha5a5_a5a0, 4'b0010);
    rd(IAT_OFF_LOWER_LIMIT, 32'h0000_a5f0);
    // reserved lanes only: nothing may be stored
    wr(IAT_OFF_UPPER_LIMIT, 32'hffff_ffff, 4'b0100);
    rd(IAT_OFF_UPPER_LIMIT, 32'h1200_fff0);
    wr(IAT_OFF_LOWER_LIMIT, 32'hffff_ffff, 4'b1100);
    rd(IAT_OFF_LOWER_LIMIT, 32'h0000_a5f0);
    for (int i = 0; i < 4; i++) begin
        r = $random(seed);
        wr(IAT_OFF_LOWER_LIMIT, {r[31:4], 4'h0}, 4'hf);
        rd(IAT_OFF_LOWER_LIMIT, {16'h0000, r[15:4], 4'h0});
    end
    apb(8'h2c, 1'b0, 32'h0, 4'hf, 32'h0, 1'b1);
    apb(8'h25, 1'b1, 32'h0, 4'hf, 32'h0, 1'b1);
    // hysteresis of one step, upper at 080h, lower at 040h
    wr(IAT_OFF_IRQ_MASK, 32'h0000_0003, 4'hf);
    wr(IAT_OFF_UPPER_LIMIT, 32'h4000_0800, 4'hf);
    wr(IAT_OFF_LOWER_LIMIT, 32'h0000_0400, 4'hf);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0000);
    samp(12'h080);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0000);
    samp(12'h081);
    lvl("alarm", 1'b1, ALARM);
    lvl("irq", 1'b1, IRQ);
    rd(IAT_OFF_IRQ_STATUS, 32'h0000_0001);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0411);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0400);
    repeat (2) @(posedge CLK);
    #1;
    lvl("alarm", 1'b0, ALARM);
    samp(12'h07f);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0400);
    samp(12'h07e);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0000);
    wr(IAT_OFF_IRQ_STATUS, 32'h0000_0001, 4'hf);
    repeat (2) @(posedge CLK);
    #1;
    lvl("irq", 1'b0, IRQ);
    // lower trip with the mask shut, then opened, then cleared
    wr(IAT_OFF_IRQ_MASK, 32'h0000_0000, 4'hf);
    samp(12'h03f);
    lvl("irq", 1'b0, IRQ);
    rd(IAT_OFF_IRQ_STATUS, 32'h0000_0002);
    wr(IAT_OFF_ALARM_FLAGS, 32'hffff_ffff, 4'hf);
    rd(IAT_OFF_ALARM_FLAGS, 32'h0000_0821);
    rd(IAT_OFF_SAMPLE, 32'h0000_003f);
    wr(IAT_OFF_IRQ_MASK, 32'h0000_0002, 4'hf);
    repeat (2) @(posedge CLK);
    #1;
    lvl("irq", 1'b1, IRQ);
    wr(IAT_OFF_IRQ_STATUS, 32'h0000_0002, 4'hf);
    repeat (2) @(posedge CLK);
    #1;
    lvl("irq", 1'b0, IRQ);
    repeat (5) @(posedge CLK);
    if (exp_q.size() != 0) begin
        fails++;
        $display("MISMATCH pending answers expected 0 seen %0d", exp_q.size());
    end
    give_verdict();
end

endmodule
